// ===== core_regs_pkg.sv
package core_regs_pkg;

  // Register map, byte addresses on the plain register port
  localparam logic [7:0] ADDR_GPR_BASE    = 8'h00; // 16 words, 0x00..0x3C
  localparam logic [7:0] ADDR_IRQ_SP      = 8'h40;
  localparam logic [7:0] ADDR_USER_SP     = 8'h44;
  localparam logic [7:0] ADDR_EXC_BASE    = 8'h48;
  localparam logic [7:0] ADDR_IRQ_BASE    = 8'h4C;
  localparam logic [7:0] ADDR_PC          = 8'h50;
  localparam logic [7:0] ADDR_STATUS_WORD = 8'h54;
  localparam logic [7:0] ADDR_BACKUP_PC   = 8'h58;
  localparam logic [7:0] ADDR_BACKUP_SW   = 8'h5C;
  localparam logic [7:0] ADDR_FAST_VECTOR = 8'h60;
  localparam logic [7:0] ADDR_CORE_STATE  = 8'h64;

  // Stack pointer select bit inside the status word
  localparam int SW_USER_SP_BIT = 17;
  // Busy flag position in the core state word
  localparam int STATE_FAST_BUSY_BIT = 0;

  // Reset values
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [31:0] RESET_PC   = 32'h0000_0000;

  // Fast interrupt entry sequencer, one-hot
  typedef enum logic [2:0] {
    FAST_IDLE   = 3'b001,
    FAST_SAVE   = 3'b010,
    FAST_BRANCH = 3'b100
  } fast_state_t;

endpackage

// ===== cpu_core_register_set.sv
// Functional notes
// [RULE_01] Sixteen 32-bit general registers serve as data or address operands.
// [RULE_02] General register zero is also the stack pointer of the core.
// [RULE_03] The status word select bit maps the stack pointer to irq or user.
// [RULE_04] Software should keep both stack pointers four-byte aligned.
// [RULE_05] An exception table base register gives the exception table start.
// [RULE_06] An irq table base register gives the irq vector table start.
// [RULE_07] The program counter holds the address of the executing instruction.
// [RULE_08] The status word reflects instruction results and core state.
// [RULE_09] A fast irq copies the program counter into the backup pc.
// [RULE_10] A fast irq copies the status word into the backup status word.
// [RULE_11] The backup status word keeps the status word bit layout unchanged.
// [RULE_12] A fast irq branches to the fast irq vector, with no memory fetch.
// [RULE_13] Both backups are saved before the vector is loaded into the pc.
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none

module cpu_core_register_set #(
  parameter int NUM_GPR = 16,
  parameter int DATA_W  = 32
) (
  input  wire logic              clock,           // Core clock, 25 MHz
  input  wire logic              rst_n,           // Async reset, low
  input  wire logic [7:0]        reg_addr,        // Register byte address
  input  wire logic [31:0]       reg_wdata,       // Register write data
  input  wire logic              reg_wr,          // Write strobe
  input  wire logic              reg_rd,          // Read strobe
  output logic      [31:0]       reg_rdata,       // Read data, next cycle
  input  wire logic              exec_wr_en,      // Result write enable
  input  wire logic [3:0]        exec_wr_idx,     // Result register index
  input  wire logic [31:0]       exec_wr_data,    // Result value
  input  wire logic [3:0]        exec_rd_idx_a,   // Operand A index
  input  wire logic [3:0]        exec_rd_idx_b,   // Operand B index
  output logic      [31:0]       operand_a,       // Operand A, next cycle
  output logic      [31:0]       operand_b,       // Operand B, next cycle
  input  wire logic              pc_load_en,      // Load next instruction addr
  input  wire logic [31:0]       pc_load_value,   // Next instruction address
  input  wire logic              sw_load_en,      // Status word update
  input  wire logic [31:0]       sw_load_value,   // New status word
  input  wire logic              fast_irq_req,    // Fast irq request pulse
  output logic                   fast_irq_ack,    // Vector taken, one pulse
  output logic      [31:0]       pc,              // Program counter
  output logic      [31:0]       status_word,     // Status word
  output logic      [31:0]       stack_ptr,       // Selected stack pointer
  output logic      [31:0]       exception_table_base, // Exception table
  output logic      [31:0]       irq_table_base   // Irq vector table
);

  // Logic serves only this shape; others are refused at elaboration
  if (NUM_GPR != 16 || DATA_W != 32)
  begin : g_shape_check
    $error("cpu_core_register_set serves 16 registers of 32 bits only");
  end

  // Storage; index 0 has no cell, it is the selected stack pointer
  logic [31:0] gpr [1:15];
  logic [31:0] next_gpr [1:15];
  logic [31:0] irq_stack_ptr;
  logic [31:0] next_irq_stack_ptr;
  logic [31:0] user_stack_ptr;
  logic [31:0] next_user_stack_ptr;
  logic [31:0] next_exception_table_base;
  logic [31:0] next_irq_table_base;
  logic [31:0] fast_irq_vector;
  logic [31:0] next_fast_irq_vector;
  logic [31:0] next_status_word;
  logic [31:0] next_pc;
  logic [31:0] backup_pc;
  logic [31:0] next_backup_pc;
  logic [31:0] backup_status_word;
  logic [31:0] next_backup_status_word;
  logic        next_fast_irq_ack;
  core_regs_pkg::fast_state_t fast_state;
  core_regs_pkg::fast_state_t next_fast_state;
  logic [31:0] next_reg_rdata;
  logic [31:0] next_operand_a;
  logic [31:0] next_operand_b;
  logic [31:0] next_stack_ptr;
  logic        use_user_sp;
  logic        fast_busy;

  // Stack pointer select follows the live status word
  assign use_user_sp =
    status_word[core_regs_pkg::SW_USER_SP_BIT]; // [RULE_03]
  assign fast_busy =
    (fast_state != core_regs_pkg::FAST_IDLE);

  // Operand read; index 0 returns the active stack pointer
  function automatic logic [31:0] gpr_read(input logic [3:0] idx);
    logic [31:0] value;
    value = 32'h0000_0000;
    if (idx == 4'h0)
      value = use_user_sp ? user_stack_ptr : irq_stack_ptr; // [RULE_02]
    else
      value = gpr[idx]; // [RULE_01]
    return value;
  endfunction

  // Bus address hits a general register slot
  function automatic logic is_gpr_addr(input logic [7:0] addr);
    return (addr[7:6] == core_regs_pkg::ADDR_GPR_BASE[7:6]) &&
           (addr[1:0] == 2'b00);
  endfunction

  // Register file next values; bus writes land after execution writes
  always_comb
  begin
    next_gpr                  = gpr;
    next_irq_stack_ptr        = irq_stack_ptr;
    next_user_stack_ptr       = user_stack_ptr;
    next_exception_table_base = exception_table_base;
    next_irq_table_base       = irq_table_base;
    next_fast_irq_vector      = fast_irq_vector;
    next_status_word          = status_word;
    if (exec_wr_en)
    begin
      if (exec_wr_idx == 4'h0)
      begin
        // Push and pop move only the selected pointer
        if (use_user_sp)
          next_user_stack_ptr = exec_wr_data; // [RULE_03]
        else
          next_irq_stack_ptr = exec_wr_data; // [RULE_02]
      end
      else
        next_gpr[exec_wr_idx] = exec_wr_data; // [RULE_01]
    end
    if (sw_load_en)
      next_status_word = sw_load_value; // [RULE_08]
    if (reg_wr)
    begin
      if (is_gpr_addr(reg_addr))
      begin
        if (reg_addr[5:2] == 4'h0)
        begin
          if (use_user_sp)
            next_user_stack_ptr = reg_wdata; // [RULE_03]
          else
            next_irq_stack_ptr = reg_wdata; // [RULE_03]
        end
        else
          next_gpr[reg_addr[5:2]] = reg_wdata; // [RULE_01]
      end
      else
      begin
        case (reg_addr)
          core_regs_pkg::ADDR_IRQ_SP:
            next_irq_stack_ptr = reg_wdata;
          core_regs_pkg::ADDR_USER_SP:
            next_user_stack_ptr = reg_wdata;
          core_regs_pkg::ADDR_EXC_BASE:
            next_exception_table_base = reg_wdata; // [RULE_05]
          core_regs_pkg::ADDR_IRQ_BASE:
            next_irq_table_base = reg_wdata; // [RULE_06]
          core_regs_pkg::ADDR_STATUS_WORD:
            next_status_word = reg_wdata; // [RULE_08]
          core_regs_pkg::ADDR_FAST_VECTOR:
            next_fast_irq_vector = reg_wdata;
          default:
            next_fast_irq_vector = fast_irq_vector;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 1; i < 16; i++)
        gpr[i] <= core_regs_pkg::RESET_WORD;
      irq_stack_ptr        <= core_regs_pkg::RESET_WORD;
      user_stack_ptr       <= core_regs_pkg::RESET_WORD;
      exception_table_base <= core_regs_pkg::RESET_WORD;
      irq_table_base       <= core_regs_pkg::RESET_WORD;
      fast_irq_vector      <= core_regs_pkg::RESET_WORD;
      status_word          <= core_regs_pkg::RESET_WORD;
    end
    else
    begin
      gpr                  <= next_gpr;
      irq_stack_ptr        <= next_irq_stack_ptr;
      user_stack_ptr       <= next_user_stack_ptr;
      exception_table_base <= next_exception_table_base;
      irq_table_base       <= next_irq_table_base;
      fast_irq_vector      <= next_fast_irq_vector;
      status_word          <= next_status_word;
    end
  end

  // Fast irq entry: save first, branch one cycle later
  // The sequencer owns the pc while busy; requests then are dropped
  always_comb
  begin
    next_fast_state         = fast_state;
    next_pc                 = pc;
    next_backup_pc          = backup_pc;
    next_backup_status_word = backup_status_word;
    next_fast_irq_ack       = 1'b0;
    case (fast_state)
      core_regs_pkg::FAST_IDLE:
      begin
        if (pc_load_en)
          next_pc = pc_load_value; // [RULE_07]
        if (reg_wr && reg_addr == core_regs_pkg::ADDR_PC)
          next_pc = reg_wdata; // [RULE_07]
        if (reg_wr && reg_addr == core_regs_pkg::ADDR_BACKUP_PC)
          next_backup_pc = reg_wdata;
        if (reg_wr && reg_addr == core_regs_pkg::ADDR_BACKUP_SW)
          next_backup_status_word = reg_wdata; // [RULE_11]
        if (fast_irq_req)
          next_fast_state = core_regs_pkg::FAST_SAVE;
      end
      core_regs_pkg::FAST_SAVE:
      begin
        // Snapshot of the interrupted instruction's context
        next_backup_pc          = pc; // [RULE_09]
        next_backup_status_word = status_word; // [RULE_10] [RULE_11]
        next_fast_state         = core_regs_pkg::FAST_BRANCH; // [RULE_13]
      end
      core_regs_pkg::FAST_BRANCH:
      begin
        // Vector comes from the register, no table read
        next_pc           = fast_irq_vector; // [RULE_12] [RULE_13]
        next_fast_irq_ack = 1'b1;
        next_fast_state   = core_regs_pkg::FAST_IDLE;
      end
      default:
        next_fast_state = core_regs_pkg::FAST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fast_state         <= core_regs_pkg::FAST_IDLE;
      pc                 <= core_regs_pkg::RESET_PC;
      backup_pc          <= core_regs_pkg::RESET_WORD;
      backup_status_word <= core_regs_pkg::RESET_WORD;
      fast_irq_ack       <= 1'b0;
    end
    else
    begin
      fast_state         <= next_fast_state;
      pc                 <= next_pc;
      backup_pc          <= next_backup_pc;
      backup_status_word <= next_backup_status_word;
      fast_irq_ack       <= next_fast_irq_ack;
    end
  end

  // Read side: bus data and operands, all registered for clean outputs
  always_comb
  begin
    next_reg_rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      if (is_gpr_addr(reg_addr))
        next_reg_rdata = gpr_read(reg_addr[5:2]);
      else
      begin
        case (reg_addr)
          core_regs_pkg::ADDR_IRQ_SP:      next_reg_rdata = irq_stack_ptr;
          core_regs_pkg::ADDR_USER_SP:     next_reg_rdata = user_stack_ptr;
          core_regs_pkg::ADDR_EXC_BASE:
            next_reg_rdata = exception_table_base; // [RULE_05]
          core_regs_pkg::ADDR_IRQ_BASE:
            next_reg_rdata = irq_table_base; // [RULE_06]
          core_regs_pkg::ADDR_PC:          next_reg_rdata = pc;
          core_regs_pkg::ADDR_STATUS_WORD: next_reg_rdata = status_word;
          core_regs_pkg::ADDR_BACKUP_PC:   next_reg_rdata = backup_pc;
          core_regs_pkg::ADDR_BACKUP_SW:
            next_reg_rdata = backup_status_word;
          core_regs_pkg::ADDR_FAST_VECTOR: next_reg_rdata = fast_irq_vector;
          core_regs_pkg::ADDR_CORE_STATE:
            next_reg_rdata[core_regs_pkg::STATE_FAST_BUSY_BIT] = fast_busy;
          default:                         next_reg_rdata = 32'h0000_0000;
        endcase
      end
    end
    next_operand_a = gpr_read(exec_rd_idx_a);
    next_operand_b = gpr_read(exec_rd_idx_b);
    next_stack_ptr = gpr_read(4'h0); // [RULE_02]
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 32'h0000_0000;
      operand_a <= 32'h0000_0000;
      operand_b <= 32'h0000_0000;
      stack_ptr <= 32'h0000_0000;
    end
    else
    begin
      reg_rdata <= next_reg_rdata;
      operand_a <= next_operand_a;
      operand_b <= next_operand_b;
      stack_ptr <= next_stack_ptr;
    end
  end

endmodule

`default_nettype wire

// ===== core_regs_assertions.sv
`timescale 1ns/10ps
`default_nettype none

module core_regs_assertions (
  input wire logic        clock,         // Core clock
  input wire logic        rst_n,         // Reset, low
  input wire logic [7:0]  reg_addr,      // Bus address
  input wire logic        reg_wr,        // Bus write
  input wire logic        reg_rd,        // Bus read
  input wire logic [31:0] reg_rdata,     // Read data
  input wire logic        exec_wr_en,    // Result write
  input wire logic [3:0]  exec_wr_idx,   // Result index
  input wire logic [31:0] exec_wr_data,  // Result value
  input wire logic [3:0]  exec_rd_idx_a, // Operand index
  input wire logic [31:0] operand_a,     // Operand value
  input wire logic        pc_load_en,    // Pc load
  input wire logic [31:0] pc_load_value, // Pc value
  input wire logic        sw_load_en,    // Status load
  input wire logic [31:0] sw_load_value, // Status value
  input wire logic        fast_irq_req,  // Fast request
  input wire logic        fast_irq_ack,  // Fast ack
  input wire logic [31:0] pc,            // Program counter
  input wire logic [31:0] status_word,   // Status word
  input wire logic [31:0] stack_ptr      // Stack pointer
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Busy window after a taken request; requests inside it are dropped
  logic [1:0] busy_cnt;
  logic [1:0] next_busy_cnt;
  always_comb
  begin
    next_busy_cnt = (busy_cnt != 2'h0) ? busy_cnt - 2'h1 : 2'h0;
    if (fast_irq_req && busy_cnt == 2'h0)
      next_busy_cnt = 2'h2;
  end
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      busy_cnt <= 2'h0;
    else
      busy_cnt <= next_busy_cnt;
  end

  sequence s_fast_taken;
    fast_irq_req && busy_cnt == 2'h0;
  endsequence
  sequence s_sp_write;
    (exec_wr_en && exec_wr_idx == 4'h0 && !reg_wr && !sw_load_en) ##1
    (!reg_wr && !sw_load_en && !(exec_wr_en && exec_wr_idx == 4'h0));
  endsequence
  sequence s_wr_then_use;
    (exec_wr_en && !reg_wr && !sw_load_en) ##1
    (exec_rd_idx_a == $past(exec_wr_idx) && !exec_wr_en && !reg_wr
     && !sw_load_en);
  endsequence

  property p_ack_time;
    s_fast_taken |=> !fast_irq_ack ##1 !fast_irq_ack ##1 fast_irq_ack;
  endproperty
  property p_ack_pulse;
    fast_irq_ack |=> !fast_irq_ack;
  endproperty
  // Pc must not move between the save and the vector load
  property p_pc_hold;
    busy_cnt == 2'h2 |=> $stable(pc);
  endproperty
  property p_pc_load;
    pc_load_en && busy_cnt == 2'h0 && !fast_irq_ack
    && !(reg_wr && reg_addr == core_regs_pkg::ADDR_PC)
    |=> pc == $past(pc_load_value);
  endproperty
  property p_sw_load;
    sw_load_en && !(reg_wr && reg_addr == core_regs_pkg::ADDR_STATUS_WORD)
    |=> status_word == $past(sw_load_value);
  endproperty
  property p_sp_write;
    s_sp_write |=> stack_ptr == $past(exec_wr_data, 2);
  endproperty
  property p_operand;
    s_wr_then_use |=> operand_a == $past(exec_wr_data, 2);
  endproperty
  property p_rd_pc;
    reg_rd && reg_addr == core_regs_pkg::ADDR_PC |=> reg_rdata == $past(pc);
  endproperty

  a_ack_time: assert property (p_ack_time)
    else $error("fast ack not three cycles after request");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("fast ack longer than one cycle");
  a_pc_hold: assert property (p_pc_hold)
    else $error("pc moved during fast entry save");
  a_pc_load: assert property (p_pc_load)
    else $error("pc load not taken");
  a_sw_load: assert property (p_sw_load)
    else $error("status word load not taken");
  a_sp_write: assert property (p_sp_write)
    else $error("stack pointer does not follow register zero");
  a_operand: assert property (p_operand)
    else $error("operand does not show written value");
  a_rd_pc: assert property (p_rd_pc)
    else $error("pc read data wrong");
endmodule

bind cpu_core_register_set core_regs_assertions u_chk (
  .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .exec_wr_en(exec_wr_en),
  .exec_wr_idx(exec_wr_idx), .exec_wr_data(exec_wr_data),
  .exec_rd_idx_a(exec_rd_idx_a), .operand_a(operand_a),
  .pc_load_en(pc_load_en), .pc_load_value(pc_load_value),
  .sw_load_en(sw_load_en), .sw_load_value(sw_load_value),
  .fast_irq_req(fast_irq_req), .fast_irq_ack(fast_irq_ack), .pc(pc),
  .status_word(status_word), .stack_ptr(stack_ptr)
);
`default_nettype wire

// ===== fast_irq_source.sv
`timescale 1ns/10ps
`default_nettype none

module fast_irq_source (
  input  wire logic clock,        // Core clock
  input  wire logic rst_n,        // Reset, low
  input  wire logic fire,         // Bench asks for an irq
  input  wire logic fast_irq_ack, // Core took the vector
  output var  logic fast_irq_req  // One-cycle request
);
  logic pending;
  // One outstanding request; fire is ignored until the ack clears pending
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fast_irq_req <= 1'b0;
      pending      <= 1'b0;
    end
    else
    begin
      fast_irq_req <= fire && !pending;
      if (fire && !pending)
        pending <= 1'b1;
      else if (fast_irq_ack)
        pending <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== tb_cpu_core_register_set.sv
`timescale 1ns/10ps
`default_nettype none

module tb_cpu_core_register_set;
  logic        clock, rst_n, reg_wr, reg_rd, exec_wr_en, fire;
  logic        pc_load_en, sw_load_en, fast_irq_req, fast_irq_ack;
  logic [7:0]  reg_addr;
  logic [3:0]  exec_wr_idx, idx_a, idx_b;
  logic [31:0] reg_wdata, reg_rdata, exec_wr_data, pc_load_value, v;
  logic [31:0] sw_load_value, operand_a, operand_b, pc, status_word;
  logic [31:0] stack_ptr, exb, irb, old_pc, old_sw;
  logic [31:0] m [25]; // Register image, index is address / 4
  int          err_total, total_checks, k, n, seed;

  cpu_core_register_set dut (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .exec_wr_en(exec_wr_en),
    .exec_wr_idx(exec_wr_idx), .exec_wr_data(exec_wr_data),
    .exec_rd_idx_a(idx_a), .exec_rd_idx_b(idx_b), .operand_a(operand_a),
    .operand_b(operand_b), .pc_load_en(pc_load_en),
    .pc_load_value(pc_load_value), .sw_load_en(sw_load_en),
    .sw_load_value(sw_load_value), .fast_irq_req(fast_irq_req),
    .fast_irq_ack(fast_irq_ack), .pc(pc), .status_word(status_word),
    .stack_ptr(stack_ptr), .exception_table_base(exb), .irq_table_base(irb));
  fast_irq_source u_src (.clock(clock), .rst_n(rst_n), .fire(fire),
    .fast_irq_ack(fast_irq_ack), .fast_irq_req(fast_irq_req));

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task results;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // Slot 0 follows the stack select bit; holes and state word give -1
  function int slot(input logic [7:0] a);
    if (a[1:0] != 2'h0 || a > 8'h60)
      return -1;
    if (a == 8'h00)
      return m[21][core_regs_pkg::SW_USER_SP_BIT] ? 17 : 16;
    return int'(a >> 2);
  endfunction
  function logic [31:0] mexp(input logic [7:0] a);
    return (slot(a) < 0) ? 32'h0 : m[slot(a)];
  endfunction
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    if (slot(a) >= 0)
      m[slot(a)] = d;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Kind 0 result write, 1 pc load, 2 status load
  task drive(input int kind, input logic [3:0] i, input logic [31:0] d);
    @(posedge clock);
    exec_wr_en <= (kind == 0);
    pc_load_en <= (kind == 1);
    sw_load_en <= (kind == 2);
    exec_wr_idx <= i;
    exec_wr_data <= d;
    pc_load_value <= d;
    sw_load_value <= d;
    idx_a <= i;
    idx_b <= ~i;
    @(posedge clock);
    exec_wr_en <= 1'b0;
    pc_load_en <= 1'b0;
    sw_load_en <= 1'b0;
    if (kind == 0)
      m[slot({2'h0, i, 2'h0})] = d;
    else
      m[kind == 1 ? 20 : 21] = d;
  endtask
  task sweep;
    for (k = 0; k <= 8'h6C; k += 2)
    begin
      rd(k[7:0], v);
      check(v, mexp(k[7:0]));
    end
    check(pc, m[20]);
    check(status_word, m[21]);
    check(stack_ptr, m[slot(8'h00)]);
    check(exb, m[18]);
    check(irb, m[19]);
  endtask

  initial
  begin
    {rst_n, reg_wr, reg_rd, exec_wr_en, fire, pc_load_en, sw_load_en} = '0;
    {reg_addr, exec_wr_idx, idx_a, idx_b, reg_wdata} = '0;
    {exec_wr_data, pc_load_value, sw_load_value} = '0;
    {err_total, total_checks} = '0;
    foreach (m[j])
      m[j] = 32'h0;
    seed = $urandom(32'h021A);
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    sweep();
    // Fill every place, read-only state word and a hole included
    for (n = 0; n <= 8'h68; n += 4)
      wr(n[7:0], (n == 0 || n == 8'h40 || n == 8'h44) ?
         $urandom & 32'hFFFF_FFFC : $urandom);
    sweep();
    // Result writes through both stack pointers, operands read back
    for (n = 0; n < 32; n++)
    begin
      if (n == 16)
        drive(2, 4'h0, m[21] ^ (32'h1 << core_regs_pkg::SW_USER_SP_BIT));
      drive(0, n[3:0], n[3:0] == 4'h0 ? $urandom & 32'hFFFF_FFFC : $urandom);
      @(posedge clock);
      #1 check(operand_a, m[slot({2'h0, n[3:0], 2'h0})]);
      check(operand_b, m[slot({2'h0, ~n[3:0], 2'h0})]);
      check(stack_ptr, m[slot(8'h00)]);
    end
    // Fast entry, with a refused pc load and pc write mid-save
    for (n = 0; n < 3; n++)
    begin
      wr(core_regs_pkg::ADDR_FAST_VECTOR, $urandom);
      drive(1, 4'h0, $urandom);
      drive(2, 4'h0, $urandom);
      {old_pc, old_sw} = {m[20], m[21]};
      @(posedge clock);
      fire <= 1'b1;
      @(posedge clock);
      fire <= 1'b0;
      @(posedge clock);
      pc_load_en <= 1'b1;
      pc_load_value <= ~old_pc;
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, core_regs_pkg::ADDR_PC, ~old_pc};
      @(posedge clock);
      // Busy flag must show while the entry sequencer is working
      {pc_load_en, reg_wr, reg_rd} <= 3'b001;
      reg_addr <= core_regs_pkg::ADDR_CORE_STATE;
      @(posedge clock);
      reg_rd <= 1'b0;
      v = 32'h1 << core_regs_pkg::STATE_FAST_BUSY_BIT;
      #1 check(reg_rdata, v);
      for (k = 0; fast_irq_ack !== 1'b1; k++)
      begin
        if (k > 8)
        begin
          err_total++;
          results();
        end
        @(posedge clock);
        #1;
      end
      {m[20], m[22], m[23]} = {m[24], old_pc, old_sw};
      check(pc, m[24]);
      rd(core_regs_pkg::ADDR_BACKUP_PC, v);
      check(v, old_pc);
      rd(core_regs_pkg::ADDR_BACKUP_SW, v);
      check(v, old_sw);
    end
    sweep();
    results();
  end
endmodule
`default_nettype wire
